// *** pkg/aux_timer_pkg.sv ***
package aux_timer_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] COUNT_OFS = 8'h04;
  localparam logic [7:0] CAPT_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] MASK_OFS = 8'h10;

  // control register field positions
  localparam int RUN_BIT = 0;
  localparam int CLR_EN_BIT = 1;
  localparam int CAP_EN_BIT = 2;
  localparam int SEL_LSB = 3;
  localparam int DIR_BIT = 5;
  localparam int CTRL_W = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

  // status and mask bit positions
  localparam int CAP_IRQ_BIT = 0;
  localparam int OVF_BIT = 1;
  localparam int STAT_W = 2;

  // edge selection codes
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_RISE = 2'h1;
  localparam logic [1:0] SEL_FALL = 2'h2;
  localparam logic [1:0] SEL_BOTH = 2'h3;

  // timer and state time
  localparam int TIMER_W = 16;
  localparam logic [TIMER_W-1:0] TIMER_ZERO = 16'h0000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int STATE_TIME_NS = 50;
  localparam int STATE_CYCLES =
    (STATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ahb transfer type and response codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage

// *** hdl/trigger_edge_detect.sv ***
`timescale 1ns/100ps
module trigger_edge_detect
  import aux_timer_pkg::*;
(
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic pin_in, // raw pin level
  input wire logic sample_en, // one pulse per state time
  input wire logic [1:0] edge_sel, // which transitions count
  output logic edge_pulse // one-cycle qualifying transition
);

  logic sync1_reg; // first stage, read only by second
  logic sync2_reg; // second stage
  logic sync3_reg; // third stage
  logic last_reg; // level seen at previous state time
  logic rise; // accepted rising transition
  logic fall; // accepted falling transition

  //////////////////////////////////////////////////////////////////////////
  // three-stage synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sample once per state time, only when stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_reg <= 1'b0;
    end else if (sample_en && (sync2_reg == sync3_reg)) begin
      last_reg <= sync3_reg;
    end
  end

  // compare successive samples
  assign rise = sample_en && (sync2_reg == sync3_reg) &&
                sync3_reg && !last_reg;
  assign fall = sample_en && (sync2_reg == sync3_reg) &&
                !sync3_reg && last_reg;

  // single shared selection for clear and capture
  always_comb begin
    case (edge_sel)
      SEL_RISE: edge_pulse = rise;
      SEL_FALL: edge_pulse = fall;
      SEL_BOTH: edge_pulse = rise | fall;
      default: edge_pulse = 1'b0;
    endcase
  end

endmodule // trigger_edge_detect

// *** hdl/aux_timer.sv ***
`timescale 1ns/100ps
// Behaviour
// - clear enable independent of capture enable
// - enabled trigger edge zeroes timer count
// - edge select: rising, falling or both
// - clear event sets capture interrupt flag
// - clear and capture share one edge
module aux_timer
  import aux_timer_pkg::*;
#(
  parameter int STATE_DIV = STATE_CYCLES // clock cycles per state time
)(
  input wire logic hclk, // bus and system clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic hready, // bus ready in
  input wire logic [31:0] hwdata, // write data
  input wire logic capture_input_pin, // external trigger pin
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // slave response
  output logic irq, // level interrupt
  output logic [TIMER_W-1:0] aux_timer_value // live count
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  localparam int DIV_W = (STATE_DIV > 1) ? $clog2(STATE_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STATE_DIV - 1);

  logic [DIV_W-1:0] div_reg; // state time divider
  logic state_tick; // one pulse per state time
  logic [CTRL_W-1:0] ctrl_reg; // aux_timer_control
  logic [TIMER_W-1:0] count_reg; // the timer itself
  logic [TIMER_W-1:0] capt_reg; // captured count
  logic [STAT_W-1:0] status_reg; // sticky events
  logic [STAT_W-1:0] mask_reg; // interrupt mask
  logic [7:0] addr_reg; // latched address of data phase
  logic wr_pend_reg; // write data phase pending
  logic trig_edge; // selected transition from detector
  logic trig_ok; // transition with pin set as input
  logic clear_evt; // timer clear event
  logic capt_evt; // capture event
  logic ovf_evt; // count wraps to zero
  logic addr_ok; // valid address phase
  logic [STAT_W-1:0] evt_vec; // events in status layout
  logic [STAT_W-1:0] w1c_vec; // bits cleared by software
  logic [31:0] rd_next; // read data for next data phase
  logic timer_run; // count enable
  logic clr_en; // timer_clear_enable
  logic cap_en; // timer_capture_enable
  logic [1:0] edge_select_field; // active edge selection
  logic pin_direction_bit; // 0 means pin is an input

  // true when a data phase writes the given offset
  function automatic logic wr_hit(input logic [7:0] ofs);
    return wr_pend_reg && (addr_reg == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // control field decode

  assign timer_run = ctrl_reg[RUN_BIT];
  assign clr_en = ctrl_reg[CLR_EN_BIT];
  assign cap_en = ctrl_reg[CAP_EN_BIT];
  assign edge_select_field = ctrl_reg[SEL_LSB +: 2];
  assign pin_direction_bit = ctrl_reg[DIR_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // state time enable

  // divider gives one enable per state time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= '0;
    end else if (div_reg == DIV_LAST) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + DIV_W'(1);
    end
  end

  assign state_tick = (div_reg == DIV_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // trigger detection

  // shared detector feeds both clear and capture
  trigger_edge_detect u_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(capture_input_pin),
    .sample_en(state_tick),
    .edge_sel(edge_select_field),
    .edge_pulse(trig_edge)
  );

  // pins driven as outputs give no trigger; a pulse shorter than the
  // sampling window can be missed, so the source must hold its level
  assign trig_ok = trig_edge && !pin_direction_bit;

  // clear and capture each gated by their own enable only
  assign clear_evt = trig_ok && clr_en;
  assign capt_evt = trig_ok && cap_en;

  // overflow when the count wraps on a tick
  assign ovf_evt = timer_run && state_tick && !clear_evt &&
                   (count_reg == {TIMER_W{1'b1}});

  ////////////////////////////////////////////////////////////////////////////
  // bus address phase

  assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans[1]);

  // latch address and direction for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= 8'h00;
      wr_pend_reg <= 1'b0;
    end else if (hready) begin
      addr_reg <= haddr[7:0];
      wr_pend_reg <= addr_ok && hwrite;
    end
  end

  // zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and mask registers

  // control writes steer the timer and the trigger path
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_hit(CTRL_OFS)) begin
      ctrl_reg <= hwdata[CTRL_W-1:0];
    end
  end

  // interrupt mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_reg <= '0;
    end else if (wr_hit(MASK_OFS)) begin
      mask_reg <= hwdata[STAT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer count

  // external clear beats a software write, which beats counting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= TIMER_ZERO;
    end else if (clear_evt) begin
      count_reg <= TIMER_ZERO;
    end else if (wr_hit(COUNT_OFS)) begin
      count_reg <= hwdata[TIMER_W-1:0];
    end else if (timer_run && state_tick) begin
      count_reg <= count_reg + TIMER_W'(1);
    end
  end

  // capture takes the count before any clear of the same edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capt_reg <= TIMER_ZERO;
    end else if (capt_evt) begin
      capt_reg <= count_reg;
    end
  end

  // live count out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aux_timer_value <= TIMER_ZERO;
    end else begin
      aux_timer_value <= count_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky status and interrupt

  always_comb begin
    evt_vec = '0;
    evt_vec[CAP_IRQ_BIT] = clear_evt || capt_evt;
    evt_vec[OVF_BIT] = ovf_evt;
    w1c_vec = wr_hit(STATUS_OFS) ? hwdata[STAT_W-1:0] : '0;
  end

  // a new event wins over a write-one-to-clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~w1c_vec) | evt_vec;
    end
  end

  // level interrupt from unmasked status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data

  // decode the read in the address phase
  always_comb begin
    rd_next = 32'h0000_0000;
    case (haddr[7:0])
      CTRL_OFS: rd_next[CTRL_W-1:0] = ctrl_reg;
      COUNT_OFS: rd_next[TIMER_W-1:0] = count_reg;
      CAPT_OFS: rd_next[TIMER_W-1:0] = capt_reg;
      STATUS_OFS: rd_next[STAT_W-1:0] = status_reg;
      MASK_OFS: rd_next[STAT_W-1:0] = mask_reg;
      default: rd_next = 32'h0000_0000;
    endcase
  end

  // registered so read data stands through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rd_next;
    end
  end

endmodule // aux_timer

// *** tb/aux_timer_monitor.sv ***
`timescale 1ns/100ps
module aux_timer_monitor
  import aux_timer_pkg::*;
#(
  parameter int STATE_DIV = STATE_CYCLES // clocks per state time
)(
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, active low
  input wire logic hsel, // select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write flag
  input wire logic [2:0] hsize, // size
  input wire logic hready, // ready in
  input wire logic [31:0] hwdata, // write data
  input wire logic capture_input_pin, // trigger pin
  input wire logic [31:0] hrdata, // read data
  input wire logic hreadyout, // ready out
  input wire logic hresp, // response
  input wire logic irq, // interrupt
  input wire logic [TIMER_W-1:0] aux_timer_value // count
);
  ////////////////////////////////////////////////////////////////////////
  logic wr_q; // write data phase pending
  logic [7:0] ofs_q; // offset of that write
  logic [CTRL_W-1:0] ctrl_sh; // control shadow
  logic mask_sh; // mask bit 0 shadow
  logic arm; // clear may fire
  logic [1:0] sel; // edge select shadow
  // follow control and mask writes from the bus
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      ofs_q <= 8'h00;
      ctrl_sh <= CTRL_RST;
      mask_sh <= 1'b0;
    end else begin
      wr_q <= hsel & hready & htrans[1] & hwrite;
      ofs_q <= haddr[7:0];
      if (wr_q && ofs_q == CTRL_OFS) begin // control write lands
        ctrl_sh <= hwdata[CTRL_W-1:0];
      end
      if (wr_q && ofs_q == MASK_OFS) begin // mask write lands
        mask_sh <= hwdata[CAP_IRQ_BIT];
      end
    end
  end
  assign arm = ctrl_sh[CLR_EN_BIT] & !ctrl_sh[DIR_BIT];
  assign sel = ctrl_sh[SEL_LSB+1:SEL_LSB];
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_clr_rise;
    $rose(capture_input_pin) && arm && sel[0]
      |-> ##[3:8] aux_timer_value == TIMER_ZERO;
  endproperty
  a_clr_rise: assert property (p_clr_rise)
    else $error("count not cleared after rising edge");
  property p_clr_fall;
    $fell(capture_input_pin) && arm && sel[1]
      |-> ##[3:8] aux_timer_value == TIMER_ZERO;
  endproperty
  a_clr_fall: assert property (p_clr_fall)
    else $error("count not cleared after falling edge");
  property p_irq_set;
    $rose(capture_input_pin) && arm && sel[0] && mask_sh |-> ##[4:9] irq;
  endproperty
  a_irq_set: assert property (p_irq_set)
    else $error("interrupt missing after clear event");
  property p_irq_masked;
    !mask_sh && $stable(mask_sh) |-> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt high while masked");
  property p_sync;
    $changed(capture_input_pin) && aux_timer_value > 16'h0003
      |-> ##1 (aux_timer_value != TIMER_ZERO) [*2];
  endproperty
  a_sync: assert property (p_sync)
    else $error("clear came before pin was synchronised");
  property p_blocked;
    $changed(capture_input_pin) && aux_timer_value > 16'h0010 &&
      !(arm && ((sel[0] && capture_input_pin) ||
      (sel[1] && !capture_input_pin)))
      |-> (aux_timer_value != TIMER_ZERO) [*8];
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("count cleared by a disabled edge");
  c_rise: cover property ($rose(capture_input_pin) && arm && sel[0]);
  c_fall: cover property ($fell(capture_input_pin) && arm && sel[1]);
  c_irq: cover property ($rose(irq));
endmodule // aux_timer_monitor

bind aux_timer aux_timer_monitor #(.STATE_DIV(STATE_DIV)) mon_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
  .hwdata(hwdata), .capture_input_pin(capture_input_pin),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
  .aux_timer_value(aux_timer_value));

// *** tb/trigger_source.sv ***
`timescale 1ns/100ps
module trigger_source (
  input wire logic hclk, // system clock
  output logic capture_input_pin // trigger level
);
  initial capture_input_pin = 1'b0;
  // change the level, then hold it n clocks (8 is four state times)
  task automatic drive(input logic lvl, input int n);
    if (capture_input_pin !== lvl) begin
      @(posedge hclk);
      capture_input_pin <= lvl;
      repeat (n) @(posedge hclk);
    end
  endtask
endmodule // trigger_source

// *** tb/test_aux_timer.sv ***
`timescale 1ns/100ps
module test_aux_timer
  import aux_timer_pkg::*;
;
  // clr cap sel dir lvl, expected clear and flag
  typedef struct packed {
    logic clr;
    logic cap;
    logic [1:0] sel;
    logic dir;
    logic lvl;
    logic clr_x;
    logic flg_x;
  } row_t;
  localparam row_t ROWS [11] = '{8'h97, 8'h90, 8'ha3, 8'ha4, 8'hb7,
    8'hb3, 8'h84, 8'h9c, 8'h55, 8'he3, 8'h34};
  localparam logic [7:0] RST_OFS [4] = '{CTRL_OFS, STATUS_OFS,
    MASK_OFS, 8'h14};
  logic hclk, hresetn, hsel, hwrite, pin, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [TIMER_W-1:0] tval;
  int err_total = 0;
  int checks = 0;
  row_t r;
  ////////////////////////////////////////////////////////////////////////
  aux_timer #(.STATE_DIV(2)) dut_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .capture_input_pin(pin), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq), .aux_timer_value(tval));
  trigger_source src_u (.hclk(hclk), .capture_input_pin(pin));
  // 40 MHz clock
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // one single word transfer, waiting on ready in both phases
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // compare one result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // report and stop
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #(25 * 8000);
    err_total++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, unmapped place, count access
    foreach (RST_OFS[i]) begin
      bus(1'b0, RST_OFS[i], 32'h0, rv);
      chk(rv, 32'h0);
    end
    // slave is always ready and always answers okay
    chk({30'h0, hresp, hreadyout}, 32'h0000_0001);
    bus(1'b1, 8'h14, 32'hffff_ffff, rv);
    bus(1'b0, 8'h14, 32'h0, rv);
    chk(rv, 32'h0);
    bus(1'b1, COUNT_OFS, 32'h0000_1234, rv);
    bus(1'b0, COUNT_OFS, 32'h0, rv);
    chk(rv, 32'h0000_1234);
    // live count output follows the stopped timer
    #1;
    chk({16'h0, tval}, 32'h0000_1234);
    $display("reset test done");
    // table of edge, select and enable cases
    foreach (ROWS[i]) begin
      r = ROWS[i];
      bus(1'b1, CTRL_OFS, 32'h0, rv);
      src_u.drive(!r.lvl, 8);
      bus(1'b1, STATUS_OFS, 32'h3, rv);
      bus(1'b1, CTRL_OFS, {26'h0, r.dir, r.sel, r.cap, r.clr, 1'b1},
        rv);
      repeat (30) @(posedge hclk);
      src_u.drive(r.lvl, 8);
      repeat (4) @(posedge hclk);
      bus(1'b0, COUNT_OFS, 32'h0, rv);
      chk({31'h0, rv[15:0] < 16'h0008}, {31'h0, r.clr_x});
      #1;
      chk({31'h0, tval < 16'h0008}, {31'h0, r.clr_x});
      bus(1'b0, STATUS_OFS, 32'h0, rv);
      chk(rv & 32'h1, {31'h0, r.flg_x});
      if (r.cap) begin
        bus(1'b0, CAPT_OFS, 32'h0, rv);
        chk({31'h0, rv[15:0] > 16'h000b}, 32'h1);
      end
      $display("row %0d done", i);
    end
    // interrupt raised, cleared, then masked
    bus(1'b1, MASK_OFS, 32'h1, rv);
    bus(1'b1, STATUS_OFS, 32'h3, rv);
    bus(1'b1, CTRL_OFS, {26'h0, 1'b0, SEL_RISE, 3'h3}, rv);
    src_u.drive(1'b0, 8);
    src_u.drive(1'b1, 12);
    #1;
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, STATUS_OFS, 32'h1, rv);
    repeat (2) @(posedge hclk);
    #1;
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, MASK_OFS, 32'h0, rv);
    src_u.drive(1'b0, 8);
    src_u.drive(1'b1, 12);
    #1;
    chk({31'h0, irq}, 32'h0);
    bus(1'b0, STATUS_OFS, 32'h0, rv);
    chk(rv & 32'h1, 32'h1);
    $display("interrupt test done");
    // mid-run reset brings irq, live count, control, count and status back to their reset values
    src_u.drive(1'b0, 8);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    #1;
    chk({31'h0, irq}, 32'h0);
    chk({16'h0, tval}, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, CTRL_OFS, 32'h0, rv);
    chk(rv, 32'h0);
    bus(1'b0, COUNT_OFS, 32'h0, rv);
    chk(rv, 32'h0);
    bus(1'b0, STATUS_OFS, 32'h0, rv);
    chk(rv, 32'h0);
    $display("mid-run reset test done");
    // count wraps from all ones and raises the overflow flag
    bus(1'b1, COUNT_OFS, 32'h0000_ffff, rv);
    bus(1'b1, CTRL_OFS, 32'h0000_0001, rv);
    repeat (6) @(posedge hclk);
    bus(1'b0, STATUS_OFS, 32'h0, rv);
    chk(rv & 32'h3, 32'h2);
    $display("overflow test done");
    complete_run();
  end
endmodule // test_aux_timer
